// [rtl/stall_pkg.sv]
// constants for the motor stall detection and ripple configuration block
package stall_pkg;
    // ==================================================
    // register byte offsets
    localparam logic [3:0] ctrl_offset = 4'h0;
    localparam logic [3:0] blank_offset = 4'h4;
    localparam logic [3:0] ripple_offset = 4'h8;
    localparam logic [3:0] status_offset = 4'hC;
    // ==================================================
    // control register field positions
    localparam int detect_enable_bit = 0;
    localparam int response_bit = 1;
    localparam int report_bit = 2;
    localparam int int_ref_bit = 3;
    localparam int limit_mode_lsb = 4;
    localparam int soft_start_bit = 6;
    localparam int fault_clear_bit = 7;
    localparam int sleep_bit = 8;
    // ripple register field positions
    localparam int ripple_enable_bit = 0;
    localparam int scale_lsb = 1;
    localparam int conductance_lsb = 8;
    // status register field positions
    localparam int blocked_flag_bit = 0;
    localparam int blanking_bit = 1;
    localparam int outputs_off_bit = 2;
    localparam int regulate_bit = 3;
    // ==================================================
    // reset values
    localparam logic [8:0] ctrl_reset = 9'h000;
    // default blanking 1 s: (1 s - 5 ms) / 102.4 us = 9717
    localparam logic [15:0] blank_reset = 16'h25F5;
    localparam logic [15:0] ripple_reset = 16'h0000;
    // ==================================================
    // timing: tick period and base interval
    localparam real clock_mhz = 250.0;
    localparam real tick_us = 102.4;
    localparam real base_ms = 5.0;
    localparam int tick_cycles = int'(tick_us * clock_mhz); // 25600
    localparam int base_ticks = int'(base_ms * 1000.0 / tick_us); // 49, nearest whole tick
    // ==================================================
    // conductance scale factors
    localparam logic [13:0] scale_by_2 = 14'h0002;
    localparam logic [13:0] scale_by_64 = 14'h0040;
    localparam logic [13:0] scale_by_1024 = 14'h0400;
    localparam logic [13:0] scale_by_8192 = 14'h2000;
    // ==================================================
    // blanking state machine
    typedef enum logic [2:0] {
        st_blank = 3'h1,
        st_watch = 3'h2,
        st_blocked = 3'h4
    } stall_state_t;
endpackage

// [rtl/motor_stall_detect_ripple_cfg.sv]
// stall detection, blanking timer and ripple configuration registers
// Functional notes
// - internal reference select picks fixed 500 mV; otherwise the reference pin voltage.
// - blocked flag in status is set whenever a stall is detected.
// - detection disabled at zero; limit mode 01b then regulates at all times.
// - after blanking expires, flag stall at first sense at or above reference.
// - 16-bit blank time in 102.4 us steps, 0000h is 5 ms, default 1 s.
// - with soft start, ramp target across blanking; host scales field by setpoint.
// - blanking restarts after power-up, fault recovery, sleep exit, stall recovery.
// - response select zero latches bridge outputs off and sets blocked flag.
// - response select one sets blocked flag while bridge keeps driving.
// - latched mode recovers by fault clear; flag clears, blanking reruns, redetects.
// - indication mode fault clear zeroes flag; after blanking stall flagged again.
// - report enable drives fault pin low while stall flagged; else pin unaffected.
// - sense at or above reference means current at or above trip: a stall.
// - ripple counting active only when ripple count enable is one.
// - conductance scale code selects 2, 64, 1024 or 8192.
// - limit mode 00b no regulation, 01b with detection during blanking, 1X always.
`timescale 1ns/100ps
module motor_stall_detect_ripple_cfg #(
    // clock cycles per blanking tick; a small value shortens simulation
    parameter int tick_count = stall_pkg::tick_cycles
) (
    input wire logic clock,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // analog interface
    input wire logic cmp_ext_ref,
    input wire logic cmp_int_ref,
    input wire logic fault_recover,
    input wire logic bridge_drive,
    output logic bridge_outputs_enable,
    output logic regulation_enable,
    output logic soft_start_active,
    output logic ripple_active,
    output logic [13:0] conductance_multiplier,
    output logic [7:0] conductance_value,
    output logic fault_pin_n
);
    // ==================================================
    // register file
    // field views below are plain slices, so decoding costs no logic
    logic [8:0] ctrl;
    logic [15:0] startup_blank_time;
    logic [15:0] ripple_cfg;
    logic ack;
    wire logic blocked_detect_enable = ctrl[stall_pkg::detect_enable_bit];
    wire logic blocked_response_select = ctrl[stall_pkg::response_bit];
    wire logic blocked_report_enable = ctrl[stall_pkg::report_bit];
    wire logic internal_reference_select = ctrl[stall_pkg::int_ref_bit];
    wire logic [1:0] current_limit_mode = ctrl[stall_pkg::limit_mode_lsb +: 2];
    wire logic soft_start_enable = ctrl[stall_pkg::soft_start_bit];
    wire logic sleep_mode = ctrl[stall_pkg::sleep_bit];
    wire logic ripple_count_enable = ripple_cfg[stall_pkg::ripple_enable_bit];
    wire logic [1:0] conductance_scale = ripple_cfg[stall_pkg::scale_lsb +: 2];

    // bus decode; every access takes one wait cycle, then completes
    // the wait cycle lets readdata come from a flop with no
    // combinational path from address to the bus; the cost is one
    // extra clock on every access, reads and writes alike
    wire logic access = read | write;
    wire logic done = access & ack;
    wire logic wr_ctrl = done & write & (address == stall_pkg::ctrl_offset);
    wire logic wr_blank = done & write & (address == stall_pkg::blank_offset);
    wire logic wr_ripple = done & write & (address == stall_pkg::ripple_offset);
    wire logic fault_clear = wr_ctrl & byteenable[0] & writedata[stall_pkg::fault_clear_bit];
    assign waitrequest = access & ~ack;

    // byte-lane merge shared by every writable register
    // only lanes 0 and 1 exist; upper lanes of a write are ignored
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                             input logic [3:0] be);
        merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    endfunction

    // ack toggles so back-to-back requests each see one wait cycle
    // ack is high only in the completing cycle, never two in a row
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    // control word as stored: the clear strobe lane is masked out
    localparam logic [8:0] strobe_mask = 9'h001 << stall_pkg::fault_clear_bit;
    wire logic [15:0] ctrl_merged = merge16({7'h00, ctrl}, writedata, byteenable);
    wire logic [8:0] next_ctrl = ctrl_merged[8:0] & ~strobe_mask;

    // control: the clear bit is never stored, so it always reads back zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl <= stall_pkg::ctrl_reset;
        end else if (wr_ctrl) begin
            ctrl <= next_ctrl;
        end
    end

    // blanking length; a new value waits for the next restart
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            startup_blank_time <= stall_pkg::blank_reset;
        end else if (wr_blank) begin
            startup_blank_time <= merge16(startup_blank_time, writedata, byteenable);
        end
    end

    // ripple enable, scale code and conductance value
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ripple_cfg <= stall_pkg::ripple_reset;
        end else if (wr_ripple) begin
            ripple_cfg <= merge16(ripple_cfg, writedata, byteenable);
        end
    end

    // ==================================================
    // comparator synchroniser
    // both comparators are analog and switch at any time; two flops
    // keep a metastable level away from the state machine, at the
    // price of two clocks of detection latency
    // the reference select is a register, so the mux ahead is safe
    logic cmp_meta;
    logic cmp_sync;
    wire logic cmp_raw = internal_reference_select ? cmp_int_ref : cmp_ext_ref;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= cmp_raw;
            cmp_sync <= cmp_meta;
        end
    end
    // sense at or above reference counts as trip current
    // a reference switch without a clear can show a stale trip for two clocks
    wire logic over_trip = cmp_sync;

    // ==================================================
    // blanking timer: tick prescaler and tick countdown
    // the interval is the programmed code plus a fixed base of whole
    // ticks, so code zero still blanks for the minimum time; a write to
    // the length register only takes effect at the next restart
    // the count only runs in the blanking state, so it idles at zero
    logic [14:0] prescale;
    logic [16:0] blank_left;
    logic sleep_q;
    logic fault_q;
    stall_pkg::stall_state_t state;
    stall_pkg::stall_state_t next_state;
    logic blocked_flag;
    logic outputs_off;

    // restart sources; power-up is covered by reset landing in st_blank
    // edge detectors reset to the idle level of their sources, so the
    // release of reset never looks like a sleep exit or a fault exit
    // sleep held high keeps the timer loaded, so blanking starts fresh on exit
    wire logic sleep_exit = sleep_q & ~sleep_mode;
    wire logic fault_exit = fault_q & ~fault_recover;
    wire logic restart = sleep_exit | fault_exit | fault_clear | sleep_mode;
    wire logic tick = (prescale == 15'(tick_count - 1));
    wire logic blank_done = (blank_left == 17'h00000);
    // 17 bits: the largest code plus the base overflows 16
    wire logic [16:0] blank_load = 17'(startup_blank_time) + 17'(stall_pkg::base_ticks);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sleep_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            sleep_q <= sleep_mode;
            fault_q <= fault_recover;
        end
    end

    // prescaler restarts with blanking so the interval is never short
    // tick marks the last cycle of each period, not the first
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prescale <= 15'h0000;
        end else if (restart || tick) begin
            prescale <= 15'h0000;
        end else begin
            prescale <= prescale + 15'h0001;
        end
    end

    // reset loads zero; the first cycle after release reloads from the register
    // the reload waits one cycle because reset must load only constants
    // until loaded is set, blank_done is ignored by the state machine
    logic loaded;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            loaded <= 1'b0;
            blank_left <= 17'h00000;
        end else begin
            loaded <= 1'b1;
            if (restart || !loaded) begin
                blank_left <= blank_load;
            end else if (state == stall_pkg::st_blank && tick && !blank_done) begin
                blank_left <= blank_left - 17'h00001;
            end
        end
    end

    // ==================================================
    // stall state machine
    // blank: detection ignored while the interval runs down
    // watch: the first synchronised trip moves to blocked
    // blocked: held until a restart; only a restart leaves it, so a
    // stall is never reported twice without a clear in between
    // detection is gated here, so disabling it drops a pending trip
    wire logic detect = blocked_detect_enable & over_trip;
    always_comb begin
        next_state = state;
        case (state)
            stall_pkg::st_blank: begin
                if (loaded && !restart && blank_done) begin
                    next_state = stall_pkg::st_watch;
                end
            end
            stall_pkg::st_watch: begin
                if (restart) begin
                    next_state = stall_pkg::st_blank;
                end else if (detect) begin
                    next_state = stall_pkg::st_blocked;
                end
            end
            stall_pkg::st_blocked: begin
                if (restart) begin
                    next_state = stall_pkg::st_blank;
                end
            end
            default: begin
                next_state = stall_pkg::st_blank;
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= stall_pkg::st_blank;
        end else begin
            state <= next_state;
        end
    end

    // flag: a clear restarts blanking, which also blocks a set in that cycle
    // so the clear always wins; a trip still standing is caught again
    // once the new blanking interval has run out
    wire logic set_flag = (state == stall_pkg::st_watch) & detect & ~restart;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            blocked_flag <= 1'b0;
            outputs_off <= 1'b0;
        end else begin
            if (set_flag) begin
                blocked_flag <= 1'b1;
                outputs_off <= ~blocked_response_select;
            end else if (fault_clear) begin
                blocked_flag <= 1'b0;
                outputs_off <= 1'b0;
            end
        end
    end

    // ==================================================
    // outputs
    // bridge enable and the fault pin are gates on flops, so they
    // move in the same cycle as the flag and the latch behind them
    // bridge_drive passes straight through unless the latch is set
    wire logic blanking = (state == stall_pkg::st_blank);
    assign bridge_outputs_enable = bridge_drive & ~outputs_off;
    // limit mode: 00 off, 01 blanking-only when detection on, 1x always
    // with detection off, mode 01 regulates at all times
    assign regulation_enable = current_limit_mode[1] |
        (current_limit_mode[0] & (~blocked_detect_enable | blanking));
    // host scales the field by the setpoint; hardware ramps over blanking
    // the ramp itself lives in the regulation loop; this is its window
    assign soft_start_active = soft_start_enable & blanking;
    assign ripple_active = ripple_count_enable & ~sleep_mode;
    assign fault_pin_n = ~(blocked_report_enable & blocked_flag);

    // conductance scale decode, held in flops
    // the multiplier trails the register by one clock; the ripple
    // datapath reads it only while counting, so the lag is harmless
    // every code maps to a power of two, so the multiply is a shift
    function automatic logic [13:0] scale_of(input logic [1:0] code);
        case (code)
            2'h0: scale_of = stall_pkg::scale_by_2;
            2'h1: scale_of = stall_pkg::scale_by_64;
            2'h2: scale_of = stall_pkg::scale_by_1024;
            default: scale_of = stall_pkg::scale_by_8192;
        endcase
    endfunction

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            conductance_multiplier <= stall_pkg::scale_by_2;
            conductance_value <= 8'h00;
        end else begin
            conductance_multiplier <= scale_of(conductance_scale);
            conductance_value <= ripple_cfg[stall_pkg::conductance_lsb +: 8];
        end
    end

    // ==================================================
    // read mux; unmapped addresses read zero
    // status is live, so a read shows the state one clock before the
    // read completes; ctrl never holds the clear strobe
    logic [31:0] next_readdata;
    // status packs flag, blanking, latch and regulation, low bit first
    wire logic [3:0] status = {regulation_enable, outputs_off, blanking, blocked_flag};
    always_comb begin
        case (address)
            stall_pkg::ctrl_offset: next_readdata = {23'h000000, ctrl};
            stall_pkg::blank_offset: next_readdata = {16'h0000, startup_blank_time};
            stall_pkg::ripple_offset: next_readdata = {16'h0000, ripple_cfg};
            stall_pkg::status_offset: next_readdata = {28'h0000000, status};
            default: next_readdata = 32'h00000000;
        endcase
    end

    // read data is captured in the wait cycle and then held until
    // the next read, so the master may take it at the completing edge
    // writes leave it alone, so it never shows a half-merged word
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h00000000;
        end else if (read && !ack) begin
            readdata <= next_readdata;
        end
    end
endmodule

// [bench/motor_model.sv]
// motor stand-in for the stall block: comparator results from a load level
`timescale 1ns/100ps
module motor_model (
    input wire logic bridge_outputs_enable,
    input wire logic [1:0] load,
    output logic cmp_ext_ref,
    output logic cmp_int_ref
);
    // no current flows while the bridge is off, so both comparators fall
    assign cmp_ext_ref = bridge_outputs_enable && load != 2'h0;
    assign cmp_int_ref = bridge_outputs_enable && load == 2'h2;
endmodule

// [bench/motor_stall_detect_ripple_cfg_asserts.sv]
// port assertions for the stall detection block
`timescale 1ns/100ps
module stall_checker #(
    parameter int tick_count = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic cmp_ext_ref,
    input wire logic cmp_int_ref,
    input wire logic bridge_drive,
    input wire logic bridge_outputs_enable,
    input wire logic ripple_active,
    input wire logic [13:0] conductance_multiplier,
    input wire logic [7:0] conductance_value,
    input wire logic fault_pin_n
);
    localparam logic [13:0] scale_tab [4] = '{14'h0002, 14'h0040, 14'h0400, 14'h2000};
    logic ctrl_wr;
    logic rip_wr;
    logic [15:0] since_rst;
    // writes at the edge where the slave takes them
    assign ctrl_wr = write && !waitrequest && address == stall_pkg::ctrl_offset;
    assign rip_wr = write && !waitrequest && address == stall_pkg::ripple_offset;
    // saturating age since reset, so the boot check never wraps
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            since_rst <= 16'h0000;
        end else if (since_rst != 16'hFFFF) begin
            since_rst <= since_rst + 16'h0001;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence req_start;
        $rose(read || write);
    endsequence
    sequence rip_lo_wr;
        rip_wr && byteenable[0];
    endsequence
    // ====
    // bus and registers
    a_wait_once: assert property (req_start |-> waitrequest ##1 !waitrequest)
        else $error("wait state not one cycle");
    a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0 |->
        readdata == 32'h0) else $error("unmapped read not zero");
    a_strobe_reads0: assert property (read && !waitrequest && address == 4'h0 |-> !readdata[7])
        else $error("fault clear read back as one");
    a_scale_decode: assert property (rip_lo_wr |-> ##2
        conductance_multiplier == scale_tab[$past(writedata[2:1], 2)]) else $error("bad scale");
    a_value_copy: assert property (rip_wr && byteenable[1] |-> ##2
        conductance_value == $past(writedata[15:8], 2)) else $error("bad conductance");
    a_ripple_off: assert property (rip_lo_wr and !writedata[0] |-> ##2 !ripple_active)
        else $error("ripple active while disabled");
    // ====
    // stall response
    a_pin_cause: assert property ($fell(fault_pin_n) && !$past(ctrl_wr) |->
        $past(cmp_ext_ref, 3) || $past(cmp_int_ref, 3)) else $error("pin fell without trip");
    a_off_cause: assert property (bridge_drive && $past(bridge_drive) &&
        $fell(bridge_outputs_enable) |-> $past(cmp_ext_ref, 3) || $past(cmp_int_ref, 3))
        else $error("bridge off without trip");
    a_idle_bridge: assert property (!bridge_drive |-> !bridge_outputs_enable)
        else $error("bridge on without drive");
    a_pin_holds: assert property (!fault_pin_n && !ctrl_wr |=> !fault_pin_n)
        else $error("fault pin released without clear");
    a_blank_boot: assert property (since_rst < 16'(48 * tick_count) |-> fault_pin_n)
        else $error("stall inside boot blanking");
endmodule
bind motor_stall_detect_ripple_cfg stall_checker #(.tick_count(tick_count)) checker_i (
    .clock(clock),
    .resetn(resetn),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .cmp_ext_ref(cmp_ext_ref),
    .cmp_int_ref(cmp_int_ref),
    .bridge_drive(bridge_drive),
    .bridge_outputs_enable(bridge_outputs_enable),
    .ripple_active(ripple_active),
    .conductance_multiplier(conductance_multiplier),
    .conductance_value(conductance_value),
    .fault_pin_n(fault_pin_n)
);

// [bench/motor_stall_detect_ripple_cfg_tb_top.sv]
// self-checking bench for the stall detection block
`timescale 1ns/100ps
module motor_stall_detect_ripple_cfg_tb_top;
    localparam int tick_count = 4;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [3:0] byteenable = 4'hF;
    logic fault_recover = 1'b0;
    logic bridge_drive = 1'b0;
    logic [1:0] load = 2'h0;
    logic [31:0] readdata, rd;
    logic waitrequest, cmp_ext_ref, cmp_int_ref, bridge_outputs_enable, regulation_enable;
    logic soft_start_active, ripple_active, fault_pin_n;
    logic [13:0] conductance_multiplier;
    logic [7:0] conductance_value;
    logic [13:0] mult_exp [4] = '{14'h0002, 14'h0040, 14'h0400, 14'h2000};
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #2 clock = ~clock;
    motor_stall_detect_ripple_cfg #(.tick_count(tick_count)) dut (.*);
    motor_model partner (.*);
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", n, e, g);
            errors++;
        end
    endtask
    task automatic chb(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    // one transfer; held until waitrequest is seen low, then an idle edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        if (wr) write <= 1'b1;
        else read <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask
    // hang guard, far above the under two thousand cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        hold(10);
        resetn <= 1'b1;
        hold(1);
        rchk("ctrl", 4'h0, 32'h0);
        rchk("blank", 4'h4, 32'h25F5);
        rchk("ripple", 4'h8, 32'h0);
        rchk("unmapped", 4'h2, 32'h0);
        bus(1'b1, 4'hC, 32'hFFFF);
        rchk("status", 4'hC, 32'h2);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 4'h8, {16'h0, 8'(8'h3C + s), 5'h0, s[1:0], s[0]});
            hold(1);
            chk("mult", {18'h0, mult_exp[s]}, {18'h0, conductance_multiplier});
            chk("value", 32'(8'h3C + s), {24'h0, conductance_value});
            chb("ripple", s[0], ripple_active);
        end
        $display("test ripple done");
        // latched stall, pin reference; the clear bit restarts a 51 tick blank
        bus(1'b1, 4'h4, 32'h2);
        bridge_drive <= 1'b1;
        load <= 2'h1;
        bus(1'b1, 4'h0, 32'h85);
        hold(150);
        chb("blanked", 1'b1, fault_pin_n);
        hold(100);
        chb("pin", 1'b0, fault_pin_n);
        chb("bridge", 1'b0, bridge_outputs_enable);
        rchk("stalled", 4'hC, 32'h5);
        bus(1'b1, 4'h0, 32'h85);
        rchk("cleared", 4'hC, 32'h2);
        rchk("strobe", 4'h0, 32'h5);
        chb("pin free", 1'b1, fault_pin_n);
        hold(250);
        chb("again", 1'b0, fault_pin_n);
        $display("test latched done");
        // indication only on the fixed reference
        bus(1'b1, 4'h0, 32'h8F);
        hold(250);
        chb("ext unused", 1'b1, fault_pin_n);
        load <= 2'h2;
        hold(20);
        chb("int trip", 1'b0, fault_pin_n);
        chb("kept", 1'b1, bridge_outputs_enable);
        bus(1'b1, 4'h0, 32'h8B);
        rchk("ind clear", 4'hC, 32'h2);
        hold(250);
        chb("no report", 1'b1, fault_pin_n);
        rchk("reflag", 4'hC, 32'h1);
        $display("test indication done");
        load <= 2'h0;
        bus(1'b1, 4'h0, 32'h90);
        chb("reg off det", 1'b1, regulation_enable);
        bus(1'b1, 4'h0, 32'h91);
        chb("reg blank", 1'b1, regulation_enable);
        hold(250);
        chb("reg after", 1'b0, regulation_enable);
        bus(1'b1, 4'h0, 32'h21);
        chb("reg always", 1'b1, regulation_enable);
        bus(1'b1, 4'h0, 32'h31);
        chb("reg mode3", 1'b1, regulation_enable);
        $display("test regulation done");
        // fault recovery and sleep exit also bring blanking back
        fault_recover <= 1'b1;
        hold(1);
        fault_recover <= 1'b0;
        hold(3);
        rchk("recover", 4'hC, 32'hA);
        hold(250);
        rchk("expired", 4'hC, 32'h8);
        bus(1'b1, 4'h0, 32'h161);
        chb("sleep", 1'b0, ripple_active);
        bus(1'b1, 4'h0, 32'h61);
        rchk("wake", 4'hC, 32'hA);
        chb("soft", 1'b1, soft_start_active);
        $display("test restart done");
        end_sim();
    end
endmodule
